// *** design/adc_ctrl_pkg.sv ***
// Shared constants: register map, field layout, reset values and pattern codes
package adc_ctrl_pkg;
    localparam int SAMPLE_W = 12;
    localparam int THR_W = 16;
    localparam int ADDR_W = 15;
    localparam int FRAME_BITS = 24;
    localparam int HDR_BITS = 16;
    // Register offsets
    localparam logic [14:0] OFS_TEST_MODE = 15'h000D;
    localparam logic [14:0] OFS_USER_FIRST = 15'h0019;
    localparam logic [14:0] OFS_USER_LAST = 15'h0020;
    localparam logic [14:0] OFS_UPPER_LO = 15'h0040;
    localparam logic [14:0] OFS_UPPER_HI = 15'h0041;
    localparam logic [14:0] OFS_LOWER_LO = 15'h0042;
    localparam logic [14:0] OFS_LOWER_HI = 15'h0043;
    localparam logic [14:0] OFS_DWELL_LO = 15'h0044;
    localparam logic [14:0] OFS_DWELL_HI = 15'h0045;
    localparam logic [14:0] OFS_CALTHR_LO = 15'h0046;
    localparam logic [14:0] OFS_CALTHR_HI = 15'h0047;
    localparam logic [14:0] OFS_CONTROL = 15'h0048;
    localparam logic [14:0] OFS_STATUS = 15'h0049;
    // Control field positions
    localparam int CTRL_GATE_EN_BIT = 0;
    localparam int CTRL_OFFSET_BIN_BIT = 1;
    // Reset values
    localparam logic [7:0] CONTROL_RESET = 8'h01;
    localparam logic [15:0] THR_RESET = 16'h0000;
    localparam logic [15:0] THR_MAX = 16'h4000;
    localparam logic [22:0] PN_SEED = 23'h7F_FFFF;
    // Magnitude scaling: 12-bit full scale 2048 maps onto threshold full scale
    localparam int MAG_SHIFT = 3;
    // Test mode codes
    localparam logic [3:0] TM_OFF = 4'h0;
    localparam logic [3:0] TM_MID = 4'h1;
    localparam logic [3:0] TM_POS_FS = 4'h2;
    localparam logic [3:0] TM_NEG_FS = 4'h3;
    localparam logic [3:0] TM_CHECKER = 4'h4;
    localparam logic [3:0] TM_PN_LONG = 4'h5;
    localparam logic [3:0] TM_TOGGLE = 4'h7;
    localparam logic [3:0] TM_USER = 4'h8;
    localparam logic [3:0] TM_RAMP = 4'hF;
    // Pattern words
    localparam logic [11:0] WORD_MID = 12'h000;
    localparam logic [11:0] WORD_POS_FS = 12'h7FF;
    localparam logic [11:0] WORD_NEG_FS = 12'h800;
    localparam logic [11:0] WORD_CHECK_A = 12'hAAA;
    localparam logic [11:0] WORD_CHECK_B = 12'h555;
    localparam logic [11:0] WORD_ONES = 12'hFFF;
    localparam logic [11:0] WORD_ZEROS = 12'h000;
endpackage

// *** design/serial_port_slave.sv ***
// Serial register port: synchronises pins, decodes read/write frames
module serial_port_slave (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clkEn,
    input wire logic serialSelectN,
    input wire logic serialClk,
    input wire logic serialDataIn,
    output logic serialDataOut,
    output logic serialDataOe,
    output logic [adc_ctrl_pkg::ADDR_W-1:0] regAddr,
    output logic wrStrobe,
    output logic [7:0] wrData,
    input wire logic [7:0] rdData
);
    typedef struct packed {
        logic [1:0] csSync;
        logic [1:0] clkSync;
        logic [1:0] datSync;
        logic clkPrev;
        logic [4:0] bitCnt;
        logic [23:0] shReg;
        logic isRead;
        logic loadPend;
        logic [7:0] outSh;
        logic oe;
        logic wrStb;
        logic [adc_ctrl_pkg::ADDR_W-1:0] addr;
    } sps_t;

    sps_t st_reg;
    sps_t st_next;
    logic rise;
    logic fall;
    logic [23:0] shNew;

    always_comb begin
        st_next = st_reg;
        rise = st_reg.clkSync[1] & ~st_reg.clkPrev;
        fall = ~st_reg.clkSync[1] & st_reg.clkPrev;
        shNew = {st_reg.shReg[22:0], st_reg.datSync[1]};
        st_next.csSync = {st_reg.csSync[0], serialSelectN};
        st_next.clkSync = {st_reg.clkSync[0], serialClk};
        st_next.datSync = {st_reg.datSync[0], serialDataIn};
        st_next.clkPrev = st_reg.clkSync[1];
        st_next.wrStb = 1'b0;
        st_next.loadPend = 1'b0;
        if (st_reg.csSync[1]) begin
            // Deselected: clock and data are ignored, frame restarts
            st_next.bitCnt = '0;
            st_next.oe = 1'b0;
            st_next.isRead = 1'b0;
        end else begin
            if (st_reg.loadPend) begin
                st_next.outSh = rdData;
                st_next.oe = 1'b1;
            end
            if (rise && st_reg.bitCnt < 5'(adc_ctrl_pkg::FRAME_BITS)) begin
                st_next.shReg = shNew;
                st_next.bitCnt = st_reg.bitCnt + 5'd1;
                if (st_reg.bitCnt == 5'(adc_ctrl_pkg::HDR_BITS - 1)) begin
                    st_next.isRead = shNew[15];
                    st_next.addr = shNew[adc_ctrl_pkg::ADDR_W-1:0];
                    st_next.loadPend = shNew[15];
                end
                // Bytes assemble into wider registers one write at a time
                if (st_reg.bitCnt == 5'(adc_ctrl_pkg::FRAME_BITS - 1) && !st_reg.isRead) begin
                    st_next.wrStb = 1'b1;
                end
            end
            // Shift only after host sampled the current bit on its rising edge
            if (fall && st_reg.oe && st_reg.bitCnt > 5'(adc_ctrl_pkg::HDR_BITS)) begin
                st_next.outSh = {st_reg.outSh[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '{csSync: 2'b11, outSh: 8'h00, shReg: 24'h00_0000, default: '0};
        end else if (clkEn) begin
            st_reg <= st_next;
        end
    end

    assign serialDataOut = st_reg.outSh[7];
    assign serialDataOe = st_reg.oe;
    assign regAddr = st_reg.addr;
    assign wrStrobe = st_reg.wrStb;
    assign wrData = st_reg.shReg[7:0];

    default clocking dc @(posedge core_clk iff clkEn); endclocking
    default disable iff (!arst_n);

    deselect_quiet_a: assert property (st_reg.csSync[1] |=> !wrStrobe && !serialDataOe)
        else $error("serial port active while deselected");
    read_drive_a: assert property ($rose(serialDataOe) |-> $past(st_reg.isRead))
        else $error("data pin driven outside a read");
    cover_write_c: cover property (wrStrobe);
    cover_read_c: cover property ($rose(serialDataOe));
endmodule // serial_port_slave

// *** design/adc_overrange_testpattern_logic.sv ***
// Converter back end: over-range flag, calibration gate, test patterns, registers
// Operation
// - Each sample is captured on the rising sample-clock edge; all stages follow it.
// - Digital reset held low returns every piece of digital logic to its reset value.
// - Over-range flag drives its own output pin for the gain stage.
// - Flag sets as soon as sample magnitude exceeds the upper threshold.
// - Flag clears only after magnitude stays below lower threshold beyond dwell.
// - Calibration gating is on after reset until software turns it off.
// - Each calibration run accumulates every sample magnitude into an average.
// - At run end with gating on, coefficients update only if average exceeds the threshold.
// - Sixteen-bit thresholds are written one byte at a time and assembled.
// - Thresholds span zero to 0x4000, the full-scale average magnitude.
// - Four-bit code in the test-mode register picks the pattern; 0000 passes samples.
// - Codes 1,2,3 give fixed words, 5 gives long PN; all formatted.
// - Checkerboard, one/zero toggle and ramp bypass the data format setting.
// - Code 1000 plays words from the user pattern registers through the formatter.
module adc_overrange_testpattern_logic #(
    parameter int CAL_LOG2 = 8
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clkEn,
    input wire logic [11:0] sampleIn,
    output logic [11:0] sampleOut,
    output logic overrangeFlag,
    output logic calUpdate,
    input wire logic serialSelectN,
    input wire logic serialClk,
    input wire logic serialDataIn,
    output logic serialDataOut,
    output logic serialDataOe
);
    localparam int ACC_W = adc_ctrl_pkg::SAMPLE_W + CAL_LOG2;

    typedef struct packed {
        logic [11:0] sample;
        logic [3:0] testMode;
        logic [7:0][7:0] userPat;
        logic [15:0] upperThr;
        logic [15:0] lowerThr;
        logic [15:0] dwell;
        logic [15:0] calThr;
        logic [7:0] control;
        logic flag;
        logic [15:0] dwellCnt;
        logic [ACC_W-1:0] calAcc;
        logic [CAL_LOG2-1:0] calCnt;
        logic calUpd;
        logic calPassed;
        logic [22:0] lfsr;
        logic [11:0] ramp;
        logic phase;
        logic [1:0] userIdx;
        logic [11:0] dataOut;
    } core_t;

    core_t st_reg;
    core_t st_next;
    logic [adc_ctrl_pkg::ADDR_W-1:0] regAddr;
    logic wrStrobe;
    logic [7:0] wrData;
    logic [7:0] rdData;
    logic [11:0] mag;
    logic [15:0] magScaled;
    logic [ACC_W-1:0] accSum;
    logic [15:0] avgScaled;
    logic [11:0] word;
    logic [11:0] userWord;
    logic formatted;
    logic gateEn;
    logic offsetBin;

    serial_port_slave u_port (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .clkEn(clkEn),
        .serialSelectN(serialSelectN),
        .serialClk(serialClk),
        .serialDataIn(serialDataIn),
        .serialDataOut(serialDataOut),
        .serialDataOe(serialDataOe),
        .regAddr(regAddr),
        .wrStrobe(wrStrobe),
        .wrData(wrData),
        .rdData(rdData)
    );

    assign gateEn = st_reg.control[adc_ctrl_pkg::CTRL_GATE_EN_BIT];
    assign offsetBin = st_reg.control[adc_ctrl_pkg::CTRL_OFFSET_BIN_BIT];

    // Register read mux
    always_comb begin
        rdData = 8'h00;
        unique case (regAddr)
            adc_ctrl_pkg::OFS_TEST_MODE: rdData = {4'h0, st_reg.testMode};
            adc_ctrl_pkg::OFS_UPPER_LO: rdData = st_reg.upperThr[7:0];
            adc_ctrl_pkg::OFS_UPPER_HI: rdData = st_reg.upperThr[15:8];
            adc_ctrl_pkg::OFS_LOWER_LO: rdData = st_reg.lowerThr[7:0];
            adc_ctrl_pkg::OFS_LOWER_HI: rdData = st_reg.lowerThr[15:8];
            adc_ctrl_pkg::OFS_DWELL_LO: rdData = st_reg.dwell[7:0];
            adc_ctrl_pkg::OFS_DWELL_HI: rdData = st_reg.dwell[15:8];
            adc_ctrl_pkg::OFS_CALTHR_LO: rdData = st_reg.calThr[7:0];
            adc_ctrl_pkg::OFS_CALTHR_HI: rdData = st_reg.calThr[15:8];
            adc_ctrl_pkg::OFS_CONTROL: rdData = st_reg.control;
            adc_ctrl_pkg::OFS_STATUS: rdData = {6'h00, st_reg.calPassed, st_reg.flag};
            default: begin
                if (regAddr >= adc_ctrl_pkg::OFS_USER_FIRST
                    && regAddr <= adc_ctrl_pkg::OFS_USER_LAST) begin
                    rdData = st_reg.userPat[3'(regAddr - adc_ctrl_pkg::OFS_USER_FIRST)];
                end
            end
        endcase
    end

    always_comb begin
        st_next = st_reg;
        // Two's complement magnitude; -2048 maps to 2048 which still fits 12 bits
        mag = st_reg.sample[11] ? 12'(-st_reg.sample) : st_reg.sample;
        magScaled = 16'({mag, 3'b000});
        accSum = st_reg.calAcc + ACC_W'(mag);
        avgScaled = 16'({accSum[ACC_W-1:CAL_LOG2], 3'b000});
        userWord = {st_reg.userPat[{st_reg.userIdx, 1'b1}],
                    st_reg.userPat[{st_reg.userIdx, 1'b0}][7:4]};
        word = st_reg.sample;
        formatted = 1'b1;

        st_next.sample = sampleIn;

        // Byte-wise register writes
        if (wrStrobe) begin
            unique case (regAddr)
                adc_ctrl_pkg::OFS_TEST_MODE: st_next.testMode = wrData[3:0];
                adc_ctrl_pkg::OFS_UPPER_LO: st_next.upperThr[7:0] = wrData;
                adc_ctrl_pkg::OFS_UPPER_HI: st_next.upperThr[15:8] = wrData;
                adc_ctrl_pkg::OFS_LOWER_LO: st_next.lowerThr[7:0] = wrData;
                adc_ctrl_pkg::OFS_LOWER_HI: st_next.lowerThr[15:8] = wrData;
                adc_ctrl_pkg::OFS_DWELL_LO: st_next.dwell[7:0] = wrData;
                adc_ctrl_pkg::OFS_DWELL_HI: st_next.dwell[15:8] = wrData;
                adc_ctrl_pkg::OFS_CALTHR_LO: st_next.calThr[7:0] = wrData;
                adc_ctrl_pkg::OFS_CALTHR_HI: st_next.calThr[15:8] = wrData;
                adc_ctrl_pkg::OFS_CONTROL: st_next.control = wrData;
                default: begin
                    if (regAddr >= adc_ctrl_pkg::OFS_USER_FIRST
                        && regAddr <= adc_ctrl_pkg::OFS_USER_LAST) begin
                        st_next.userPat[3'(regAddr - adc_ctrl_pkg::OFS_USER_FIRST)] = wrData;
                    end
                end
            endcase
        end

        // Over-range detector with hysteresis
        if (magScaled > st_reg.upperThr) begin
            st_next.flag = 1'b1;
            st_next.dwellCnt = '0;
        end else if (st_reg.flag) begin
            if (magScaled >= st_reg.lowerThr) begin
                st_next.dwellCnt = '0;
            end else if (st_reg.dwellCnt >= st_reg.dwell) begin
                // Below lower threshold for dwell+1 samples, i.e. longer than dwell
                st_next.flag = 1'b0;
                st_next.dwellCnt = '0;
            end else begin
                st_next.dwellCnt = st_reg.dwellCnt + 16'd1;
            end
        end

        // Calibration runs back to back; each run is 2**CAL_LOG2 samples
        st_next.calAcc = accSum;
        st_next.calCnt = st_reg.calCnt + CAL_LOG2'(1);
        st_next.calUpd = 1'b0;
        if (&st_reg.calCnt) begin
            st_next.calAcc = '0;
            // Gating on: update only when the average exceeds the threshold
            if (!gateEn || avgScaled > st_reg.calThr) begin
                st_next.calUpd = 1'b1;
            end
            st_next.calPassed = avgScaled > st_reg.calThr;
        end

        // Pattern sources run freely so switching modes needs no restart
        st_next.lfsr = {st_reg.lfsr[21:0], st_reg.lfsr[22] ^ st_reg.lfsr[17]};
        st_next.ramp = st_reg.ramp + 12'd1;
        st_next.phase = ~st_reg.phase;
        st_next.userIdx = st_reg.userIdx + 2'd1;

        unique case (st_reg.testMode)
            adc_ctrl_pkg::TM_MID: word = adc_ctrl_pkg::WORD_MID;
            adc_ctrl_pkg::TM_POS_FS: word = adc_ctrl_pkg::WORD_POS_FS;
            adc_ctrl_pkg::TM_NEG_FS: word = adc_ctrl_pkg::WORD_NEG_FS;
            adc_ctrl_pkg::TM_PN_LONG: word = st_reg.lfsr[11:0];
            adc_ctrl_pkg::TM_CHECKER: begin
                word = st_reg.phase ? adc_ctrl_pkg::WORD_CHECK_B : adc_ctrl_pkg::WORD_CHECK_A;
                formatted = 1'b0;
            end
            adc_ctrl_pkg::TM_TOGGLE: begin
                word = st_reg.phase ? adc_ctrl_pkg::WORD_ZEROS : adc_ctrl_pkg::WORD_ONES;
                formatted = 1'b0;
            end
            adc_ctrl_pkg::TM_RAMP: begin
                word = st_reg.ramp;
                formatted = 1'b0;
            end
            adc_ctrl_pkg::TM_USER: word = userWord;
            default: word = st_reg.sample;
        endcase
        // Offset binary flips the sign bit of formatted words only
        st_next.dataOut = (formatted && offsetBin) ? {~word[11], word[10:0]} : word;
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            // Fields cleared except gating enabled, upper threshold 0x4000 and PN seed loaded
            st_reg <= '{control: adc_ctrl_pkg::CONTROL_RESET,
                        upperThr: adc_ctrl_pkg::THR_MAX,
                        lowerThr: adc_ctrl_pkg::THR_RESET,
                        lfsr: adc_ctrl_pkg::PN_SEED,
                        default: '0};
        end else if (clkEn) begin
            st_reg <= st_next;
        end
    end

    assign overrangeFlag = st_reg.flag;
    assign calUpdate = st_reg.calUpd;
    assign sampleOut = st_reg.dataOut;

    default clocking dc @(posedge core_clk iff clkEn); endclocking
    default disable iff (!arst_n);

    flag_set_a: assert property (magScaled > st_reg.upperThr |=> overrangeFlag)
        else $error("flag not set above upper threshold");
    flag_clear_a: assert property ($fell(overrangeFlag) |-> $past(magScaled) < $past(st_reg.lowerThr)
                                   && $past(st_reg.dwellCnt) >= $past(st_reg.dwell))
        else $error("flag cleared without dwell");
    dwell_restart_a: assert property (st_reg.flag && magScaled >= st_reg.lowerThr
                                      |=> st_reg.dwellCnt == 16'h0000)
        else $error("dwell count not restarted");
    cal_gate_a: assert property (&st_reg.calCnt && gateEn && !(avgScaled > st_reg.calThr)
                                 |=> !calUpdate)
        else $error("coefficient update below threshold");
    cal_period_a: assert property (calUpdate |-> st_reg.calCnt == '0)
        else $error("update outside run end");
    pos_fs_a: assert property (st_reg.testMode == adc_ctrl_pkg::TM_POS_FS && !offsetBin
                               |=> sampleOut == 12'h7FF)
        else $error("positive full scale word wrong");
    checker_alt_a: assert property (st_reg.testMode == adc_ctrl_pkg::TM_CHECKER [*2]
                                    |=> sampleOut == ~$past(sampleOut))
        else $error("checkerboard not alternating");
    ramp_step_a: assert property (st_reg.testMode == adc_ctrl_pkg::TM_RAMP [*2]
                                  |=> sampleOut == 12'($past(sampleOut) + 12'd1))
        else $error("ramp not incrementing");
    pass_through_a: assert property (st_reg.testMode == adc_ctrl_pkg::TM_OFF && !offsetBin
                                     |=> sampleOut == $past(st_reg.sample))
        else $error("normal samples not passed");
    cover_flag_c: cover property ($rose(overrangeFlag) ##[1:50] $fell(overrangeFlag));
    cover_cal_c: cover property (calUpdate);
    cover_user_c: cover property (st_reg.testMode == adc_ctrl_pkg::TM_USER);
endmodule // adc_overrange_testpattern_logic

// *** test/frontend_model.sv ***
// Gain stage and sample source on the converter's far side
module frontend_model (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [11:0] level,
    input wire logic overrangeFlag,
    output logic [11:0] sampleIn,
    output int gainCuts
);
    timeunit 1ns;
    timeprecision 1ps;
    logic flagSeen;
    // Samples launch just after the rising edge, so the converter takes them on the next one
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sampleIn <= 12'h000;
            flagSeen <= 1'b0;
            gainCuts <= 0;
        end else begin
            sampleIn <= level;
            flagSeen <= overrangeFlag;
            // One gain step per rising flag, taken straight from the pin
            if (overrangeFlag && !flagSeen) gainCuts <= gainCuts + 1;
        end
    end
endmodule // frontend_model

// *** test/testbench.sv ***
// Self-checking bench: serial registers, over-range flag, calibration gate, test patterns
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CAL_LOG2 = 2;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic serialSelectN = 1'b1;
    logic serialClk = 1'b0;
    logic serialDataIn = 1'b0;
    logic [11:0] level = 12'h000;
    logic [11:0] sampleIn, sampleOut, prevOut;
    logic overrangeFlag, calUpdate, serialDataOut, serialDataOe;
    logic [7:0] rdByte;
    logic oeSeen;
    logic clkEn = 1'b1;
    int gainCuts;
    int errors = 0;
    int compares = 0;
    int pulses;
    logic [3:0] fixCode [4] = '{4'h1, 4'h2, 4'h3, 4'h8};
    logic [11:0] fixWord [4] = '{12'h000, 12'h7FF, 12'h800, 12'h3AC};
    logic [3:0] altCode [3] = '{4'h4, 4'h7, 4'hF};

    always #5 core_clk = ~core_clk;

    frontend_model u_frontend_model (.core_clk(core_clk), .arst_n(arst_n), .level(level),
        .overrangeFlag(overrangeFlag), .sampleIn(sampleIn), .gainCuts(gainCuts));
    adc_overrange_testpattern_logic #(.CAL_LOG2(CAL_LOG2)) u_adc_overrange_testpattern_logic (
        .core_clk(core_clk), .arst_n(arst_n), .clkEn(clkEn), .sampleIn(sampleIn),
        .sampleOut(sampleOut), .overrangeFlag(overrangeFlag), .calUpdate(calUpdate),
        .serialSelectN(serialSelectN), .serialClk(serialClk), .serialDataIn(serialDataIn),
        .serialDataOut(serialDataOut), .serialDataOe(serialDataOe));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // Each serial clock level spans 8 cycles, well above the synchroniser's minimum of 4
    task automatic frame(input logic rd, input logic [14:0] addr, input logic [7:0] data,
        input logic sel = 1'b0);
        logic [23:0] bits;
        bits = {rd, addr, data};
        cycles(1);
        serialSelectN <= sel;
        cycles(4);
        for (int i = 23; i >= 0; i--) begin
            serialDataIn <= bits[i];
            cycles(8);
            if (i < 8) rdByte[i] = serialDataOut;
            if (i == 0) oeSeen = serialDataOe;
            serialClk <= 1'b1;
            cycles(8);
            serialClk <= 1'b0;
        end
        cycles(8);
        serialSelectN <= 1'b1;
        cycles(8);
    endtask

    task automatic wr(input logic [14:0] addr, input logic [7:0] data);
        frame(1'b0, addr, data);
    endtask

    task automatic rd(input logic [14:0] addr, input logic [7:0] exp, input string what);
        frame(1'b1, addr, 8'h00);
        check(what, {8'h00, rdByte}, {8'h00, exp});
        check("data drive", oeSeen, 1'b1);
    endtask

    task automatic count_pulses(input int n);
        pulses = 0;
        repeat (n) begin
            @(posedge core_clk);
            #1;
            if (calUpdate === 1'b1) pulses++;
        end
    endtask

    function automatic logic [11:0] alt_next(input int k, input logic [11:0] p);
        case (k)
            0: return (p === 12'hAAA) ? 12'h555 : 12'hAAA;
            1: return (p === 12'hFFF) ? 12'h000 : 12'hFFF;
            default: return p + 12'h001;
        endcase
    endfunction

    initial begin
        cycles(100000);
        errors++;
        report_and_stop();
    end

    initial begin
        cycles(16);
        arst_n <= 1'b1;
        cycles(4);
        rd(adc_ctrl_pkg::OFS_CONTROL, adc_ctrl_pkg::CONTROL_RESET, "control");
        rd(adc_ctrl_pkg::OFS_TEST_MODE, 8'h00, "test mode");
        rd(adc_ctrl_pkg::OFS_UPPER_HI, 8'h40, "upper hi");
        rd(15'h0030, 8'h00, "unmapped");
        frame(1'b0, adc_ctrl_pkg::OFS_TEST_MODE, 8'h02, 1'b1);
        check("deselected drive", oeSeen, 1'b0);
        rd(adc_ctrl_pkg::OFS_TEST_MODE, 8'h00, "deselected frame");
        // Upper 0x2000, lower 0x1000, dwell 3
        wr(adc_ctrl_pkg::OFS_UPPER_HI, 8'h20);
        wr(adc_ctrl_pkg::OFS_LOWER_HI, 8'h10);
        wr(adc_ctrl_pkg::OFS_DWELL_LO, 8'h03);
        rd(adc_ctrl_pkg::OFS_UPPER_HI, 8'h20, "upper hi");
        rd(adc_ctrl_pkg::OFS_DWELL_LO, 8'h03, "dwell lo");
        level <= 12'hC00;
        cycles(6);
        check("flag at threshold", overrangeFlag, 1'b0);
        level <= 12'hBFF;
        cycles(4);
        check("flag set", overrangeFlag, 1'b1);
        // Three low samples, one at the lower threshold, three low: count must restart
        level <= 12'h064;
        cycles(3);
        level <= 12'h200;
        cycles(1);
        level <= 12'h064;
        cycles(3);
        level <= 12'h200;
        cycles(6);
        check("flag held", overrangeFlag, 1'b1);
        level <= 12'h064;
        cycles(9);
        check("flag cleared", overrangeFlag, 1'b0);
        check("gain cuts", gainCuts[15:0], 16'h0001);
        level <= 12'h123;
        cycles(6);
        check("pass through", sampleOut, 12'h123);
        for (int b = 0; b < 8; b++) begin
            wr(adc_ctrl_pkg::OFS_USER_FIRST + 15'(b), b[0] ? 8'h3A : 8'hC5);
        end
        for (int k = 0; k < 4; k++) begin
            wr(adc_ctrl_pkg::OFS_TEST_MODE, {4'h0, fixCode[k]});
            check("fixed pattern", sampleOut, fixWord[k]);
        end
        wr(adc_ctrl_pkg::OFS_CONTROL, 8'h03);
        check("user offset", sampleOut, 12'hBAC);
        wr(adc_ctrl_pkg::OFS_TEST_MODE, 8'h02);
        check("full scale offset", sampleOut, 12'hFFF);
        for (int k = 0; k < 3; k++) begin
            wr(adc_ctrl_pkg::OFS_TEST_MODE, {4'h0, altCode[k]});
            prevOut = sampleOut;
            cycles(1);
            check("alternating", sampleOut, alt_next(k, prevOut));
        end
        // Enable low must freeze even the free-running ramp
        clkEn <= 1'b0;
        cycles(1);
        prevOut = sampleOut;
        cycles(3);
        check("frozen ramp", sampleOut, prevOut);
        clkEn <= 1'b1;
        wr(adc_ctrl_pkg::OFS_TEST_MODE, 8'h05);
        prevOut = sampleOut;
        cycles(1);
        check("pn moving", 16'(sampleOut !== prevOut), 16'h0001);
        // Calibration threshold 8: runs of 1s average exactly 8, runs of 2s average 16
        wr(adc_ctrl_pkg::OFS_TEST_MODE, 8'h00);
        wr(adc_ctrl_pkg::OFS_CONTROL, 8'h01);
        wr(adc_ctrl_pkg::OFS_CALTHR_LO, 8'h08);
        level <= 12'h001;
        cycles(8);
        count_pulses(16);
        check("gated at threshold", pulses[15:0], 16'h0000);
        level <= 12'h002;
        cycles(8);
        count_pulses(16);
        check("updates above", pulses[15:0], 16'h0004);
        rd(adc_ctrl_pkg::OFS_STATUS, 8'h02, "status");
        level <= 12'h001;
        wr(adc_ctrl_pkg::OFS_CONTROL, 8'h00);
        count_pulses(16);
        check("ungated updates", pulses[15:0], 16'h0004);
        wr(adc_ctrl_pkg::OFS_TEST_MODE, 8'h02);
        arst_n <= 1'b0;
        cycles(2);
        check("reset output", sampleOut, 12'h000);
        arst_n <= 1'b1;
        cycles(4);
        rd(adc_ctrl_pkg::OFS_TEST_MODE, 8'h00, "mode after reset");
        report_and_stop();
    end
endmodule // testbench
